/* hdl/lv_reset_pkg.sv */
// Constants, register layout and carrier types of the low-voltage reset control
// Operation
// - Detector active only while enable bit set
// - Stop switches detector off unless stop-enable
// - Both enables turn deep stop into retained
// - Power-on detector forces reset
// - After power-on hold reset until above low threshold
// - Power-on sets power-on and low-supply flags; a power-on during the low-supply hold does not set the power-on flag
// - Reset enable plus low detection gives reset
// - Threshold chosen by threshold-select bit
// - After low reset hold until above threshold
// - Low-supply cause flag set on both resets
// - Warning with enable sets flag and interrupt
// - Reset entry records active causes, clears others
package lv_reset_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] power_mgmt_control_1_offs = 4'h0;
    localparam logic [3:0] reset_cause_register_offs = 4'h4;
    localparam logic [3:0] irq_status_offs = 4'h8;
    localparam logic [3:0] irq_mask_offs = 4'hc;
    localparam logic [3:0] stop_request_offs = 4'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ctl_warning_flag_bit = 7;
    localparam int ctl_warning_ack_bit = 6;
    localparam int ctl_warning_ie_bit = 5;
    localparam int ctl_threshold_bit = 4;
    localparam int ctl_reset_en_bit = 3;
    localparam int ctl_stop_en_bit = 2;
    localparam int ctl_det_en_bit = 0;
    localparam int cause_por_bit = 7;
    localparam int cause_low_bit = 1;
    localparam int evt_warning_bit = 0;
    localparam int evt_low_reset_bit = 1;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] ctl_reset_value = 8'h1c;
    localparam logic [7:0] cause_por_value = 8'h82;
    localparam logic [1:0] mask_reset_value = 2'h0;
    localparam int reset_stretch_ns = 200;
    localparam int clk_period_ns = 25;
    localparam int reset_stretch_cycles =
        (reset_stretch_ns + clk_period_ns - 1) / clk_period_ns;

    typedef struct packed {
        logic warning_interrupt_enable;
        logic threshold_select;
        logic low_supply_reset_enable;
        logic detector_stop_enable;
        logic detector_enable;
    } control_type;

    typedef struct packed {
        logic por;
        logic low_supply;
    } cause_type;

    typedef enum logic [1:0] {
        stop_none = 2'h0,
        stop_retained = 2'h1,
        stop_deep = 2'h2
    } stop_mode_type;

endpackage

/* hdl/lv_reset_sync.sv */
// Two-flop synchroniser bank for the analog comparator inputs
`timescale 1ns/100ps
module lv_reset_sync #(
    parameter int width = 4
) (
    input wire logic i_clk,                 // Bus clock
    input wire logic i_reset,               // Async reset
    input wire logic [width-1:0] i_async,   // Unsynchronised levels
    output logic [width-1:0] o_sync         // Synchronised levels
);
    logic [width-1:0] meta_q;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // lv_reset_sync

/* hdl/lv_reset_ctrl.sv */
// Low-voltage detect, reset hold, cause flags and warning interrupt
`timescale 1ns/100ps
module lv_reset_ctrl (
    input wire logic i_clk,                 // Bus clock, 40 MHz
    input wire logic i_reset,               // Async reset, active high
    input wire logic i_por_detect,          // Power-on comparator, high at power-up
    input wire logic i_below_low,           // Supply below low threshold
    input wire logic i_below_high,          // Supply below high threshold
    input wire logic i_warning_detect,      // Supply below warning level
    input wire logic i_stop_request,        // Core requests stop, level
    input wire logic i_stop_deep,           // Requested stop is the deep one
    input wire logic [3:0] s_axi_awaddr,    // AXI write address
    input wire logic s_axi_awvalid,         // AXI write address valid
    output logic s_axi_awready,             // AXI write address ready
    input wire logic [31:0] s_axi_wdata,    // AXI write data
    input wire logic [3:0] s_axi_wstrb,     // AXI write strobes
    input wire logic s_axi_wvalid,          // AXI write data valid
    output logic s_axi_wready,              // AXI write data ready
    output logic [1:0] s_axi_bresp,         // AXI write response
    output logic s_axi_bvalid,              // AXI write response valid
    input wire logic s_axi_bready,          // AXI write response ready
    input wire logic [3:0] s_axi_araddr,    // AXI read address
    input wire logic s_axi_arvalid,         // AXI read address valid
    output logic s_axi_arready,             // AXI read address ready
    output logic [31:0] s_axi_rdata,        // AXI read data
    output logic [1:0] s_axi_rresp,         // AXI read response
    output logic s_axi_rvalid,              // AXI read valid
    input wire logic s_axi_rready,          // AXI read ready
    output logic o_detector_on,             // Analog detector enable
    output logic o_threshold_high,          // Selects high detection threshold
    output logic [1:0] o_stop_mode,         // Granted stop mode
    output logic o_system_reset,            // System reset request
    output logic o_warning_irq,             // Warning interrupt request
    output logic o_irq                      // Combined masked event interrupt
);
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [3:0] sync_w;

    lv_reset_sync #(.width(4)) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async({i_por_detect, i_below_low, i_below_high, i_warning_detect}),
        .o_sync(sync_w)
    );

    wire por_w = sync_w[3];
    wire below_low_w = sync_w[2];
    wire below_high_w = sync_w[1];
    wire warn_w = sync_w[0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_run = 3'h1,
        st_por_hold = 3'h2,
        st_low_hold = 3'h4
    } rst_state_type;

    rst_state_type state_q, state_d;
    lv_reset_pkg::control_type ctl_q;
    lv_reset_pkg::cause_type cause_q;
    logic warning_flag_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [7:0] stretch_q;
    logic stop_active_q;

    // ------------------------------------------------------------
    // Detector control and stop-mode steering
    // ------------------------------------------------------------
    // In stop the detector only survives with the stop enable set
    wire det_on_w = ctl_q.detector_enable
        & (~stop_active_q | ctl_q.detector_stop_enable);
    wire keep_det_w = ctl_q.detector_enable & ctl_q.detector_stop_enable;
    wire [1:0] stop_grant_w = ~i_stop_request ? 2'(lv_reset_pkg::stop_none) :
        (i_stop_deep & ~keep_det_w) ? 2'(lv_reset_pkg::stop_deep) :
        2'(lv_reset_pkg::stop_retained);
    wire [1:0] stop_mode_d = stop_grant_w;

    // Threshold compare picks the comparator for the selected level
    wire below_sel_w = ctl_q.threshold_select ? below_high_w : below_low_w;
    wire low_trip_w = det_on_w & ctl_q.low_supply_reset_enable & below_sel_w;
    wire warn_evt_w = det_on_w & warn_w;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            st_run:
            begin
                if (por_w)
                    state_d = st_por_hold;
                else if (low_trip_w)
                    state_d = st_low_hold;
            end
            st_por_hold:
            begin
                // Low comparator releases power-on hold regardless of enables
                if (!por_w && !below_low_w && stretch_q == 8'h0)
                    state_d = st_run;
            end
            st_low_hold:
            begin
                if (por_w)
                    state_d = st_por_hold;
                else if (!below_sel_w && stretch_q == 8'h0)
                    state_d = st_run;
            end
            default: state_d = st_por_hold;
        endcase
    end

    wire entering_w = (state_q == st_run) && (state_d != st_run);
    wire reset_d = (state_d != st_run);

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q <= st_por_hold;
            stretch_q <= 8'(lv_reset_pkg::reset_stretch_cycles);
            o_system_reset <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            o_system_reset <= reset_d;
            if (entering_w)
                stretch_q <= 8'(lv_reset_pkg::reset_stretch_cycles);
            else if (stretch_q != 8'h0)
                stretch_q <= stretch_q - 8'h1;
        end
    end

    // ------------------------------------------------------------
    // Reset-cause recording
    // ------------------------------------------------------------
    // A controller reset is a power-on: both flags come up set
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            cause_q <= '{por: 1'b1, low_supply: 1'b1};
        else if (entering_w)
        begin
            cause_q.por <= (state_d == st_por_hold);
            cause_q.low_supply <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [3:0] awaddr_q;
    logic aw_held_q, w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire aw_take_w = s_axi_awvalid & s_axi_awready;
    wire w_take_w = s_axi_wvalid & s_axi_wready;
    wire do_write_w = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_ctl_w = do_write_w && awaddr_q == lv_reset_pkg::power_mgmt_control_1_offs
        && wstrb_q[0];
    wire wr_mask_w = do_write_w && awaddr_q == lv_reset_pkg::irq_mask_offs && wstrb_q[0];
    wire wr_ok_w = awaddr_q == lv_reset_pkg::power_mgmt_control_1_offs
        || awaddr_q == lv_reset_pkg::reset_cause_register_offs
        || awaddr_q == lv_reset_pkg::irq_status_offs
        || awaddr_q == lv_reset_pkg::irq_mask_offs;
    wire ack_warn_w = wr_ctl_w & wdata_q[lv_reset_pkg::ctl_warning_ack_bit];
    wire ar_take_w = s_axi_arvalid & s_axi_arready;
    wire rd_status_w = ar_take_w && s_axi_araddr == lv_reset_pkg::irq_status_offs;

    wire [7:0] ctl_rd_w = {warning_flag_q, 1'b0, ctl_q.warning_interrupt_enable,
        ctl_q.threshold_select, ctl_q.low_supply_reset_enable,
        ctl_q.detector_stop_enable, 1'b0, ctl_q.detector_enable};
    wire [7:0] cause_rd_w = {cause_q.por, 5'h0, cause_q.low_supply, 1'b0};
    wire rd_ok_w = s_axi_araddr == lv_reset_pkg::power_mgmt_control_1_offs
        || s_axi_araddr == lv_reset_pkg::reset_cause_register_offs
        || s_axi_araddr == lv_reset_pkg::irq_status_offs
        || s_axi_araddr == lv_reset_pkg::irq_mask_offs;
    wire [31:0] rd_mux_w =
        (s_axi_araddr == lv_reset_pkg::power_mgmt_control_1_offs) ? {24'h0, ctl_rd_w} :
        (s_axi_araddr == lv_reset_pkg::reset_cause_register_offs) ? {24'h0, cause_rd_w} :
        (s_axi_araddr == lv_reset_pkg::irq_status_offs) ? {30'h0, status_q} :
        (s_axi_araddr == lv_reset_pkg::irq_mask_offs) ? {30'h0, mask_q} : 32'h0;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            s_axi_awready <= ~aw_held_q & ~aw_take_w & ~s_axi_awready;
            s_axi_wready <= ~w_held_q & ~w_take_w & ~s_axi_wready;
            if (aw_take_w)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (w_take_w)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write_w)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok_w ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take_w & ~s_axi_arready;
            if (ar_take_w)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux_w;
                s_axi_rresp <= rd_ok_w ? 2'h0 : 2'h2;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register, warning flag and event status
    // ------------------------------------------------------------
    wire warn_set_w = warn_evt_w & ctl_q.warning_interrupt_enable;
    wire [1:0] evt_w = {entering_w & (state_d == st_low_hold), warn_set_w};

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctl_q <= lv_reset_pkg::ctl_reset_value[5:0] == 6'h0 ? '0 :
                {lv_reset_pkg::ctl_reset_value[5:2], lv_reset_pkg::ctl_reset_value[0]};
            warning_flag_q <= 1'b0;
            status_q <= 2'h0;
            mask_q <= lv_reset_pkg::mask_reset_value;
            stop_active_q <= 1'b0;
            o_stop_mode <= 2'(lv_reset_pkg::stop_none);
            o_detector_on <= 1'b0;
            o_threshold_high <= 1'b0;
            o_warning_irq <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            if (wr_ctl_w)
                ctl_q <= {wdata_q[5:2], wdata_q[0]};
            // A new warning beats a simultaneous acknowledge
            warning_flag_q <= warn_set_w | (warning_flag_q & ~ack_warn_w);
            status_q <= evt_w | (status_q & {2{~rd_status_w}});
            if (wr_mask_w)
                mask_q <= wdata_q[1:0];
            stop_active_q <= i_stop_request;
            o_stop_mode <= stop_mode_d;
            o_detector_on <= det_on_w;
            o_threshold_high <= ctl_q.threshold_select;
            o_warning_irq <= (warn_set_w | (warning_flag_q & ~ack_warn_w))
                & ctl_q.warning_interrupt_enable;
            o_irq <= |((evt_w | (status_q & {2{~rd_status_w}})) & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence por_seen;
        por_w;
    endsequence

    chk_detector_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        !ctl_q.detector_enable |=> !o_detector_on)
        else $error("detector on while disabled");
    chk_stop_off: assert property (@(posedge i_clk) disable iff (i_reset)
        stop_active_q && !ctl_q.detector_stop_enable |=> !o_detector_on)
        else $error("detector on in stop");
    chk_deep_redirect: assert property (@(posedge i_clk) disable iff (i_reset)
        i_stop_request && keep_det_w |=> o_stop_mode != 2'(lv_reset_pkg::stop_deep))
        else $error("deep stop entered with detector kept");
    chk_por_reset: assert property (@(posedge i_clk) disable iff (i_reset)
        por_seen |=> o_system_reset)
        else $error("no reset on power-on");
    chk_por_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == st_por_hold && below_low_w |=> o_system_reset)
        else $error("released while below low threshold");
    chk_low_trip: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == st_run && low_trip_w |=> o_system_reset ##0 cause_q.low_supply)
        else $error("low supply did not reset");
    chk_low_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == st_low_hold && below_sel_w |=> o_system_reset)
        else $error("released while below threshold");
    chk_cause_por: assert property (@(posedge i_clk) disable iff (i_reset)
        entering_w && state_d == st_por_hold |=> cause_q.por && cause_q.low_supply)
        else $error("power-on causes not recorded");
    chk_cause_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        entering_w && state_d == st_low_hold |=> !cause_q.por)
        else $error("inactive cause kept");
    chk_warn_set: assert property (@(posedge i_clk) disable iff (i_reset)
        warn_set_w |=> warning_flag_q && o_warning_irq)
        else $error("warning not flagged");
    chk_no_warn_off: assert property (@(posedge i_clk) disable iff (i_reset)
        !det_on_w && !warning_flag_q && !ack_warn_w |=> !warning_flag_q)
        else $error("warning while detector off");
    chk_threshold_out: assert property (@(posedge i_clk) disable iff (i_reset)
        $changed(ctl_q.threshold_select) |=> o_threshold_high == ctl_q.threshold_select)
        else $error("threshold output stale");
endmodule // lv_reset_ctrl

/* verif/tb_top.sv */
// Self-checking testbench of the low-voltage reset controller
`timescale 1ns/100ps
module tb_top;
    logic i_clk, i_reset, i_por_detect, i_below_low, i_below_high, i_warning_detect;
    logic i_stop_request, i_stop_deep, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, o_detector_on, o_threshold_high;
    logic o_system_reset, o_warning_irq, o_irq;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, o_stop_mode, rsp;
    logic [7:0] ctl;
    int fail_count, n_compared;
    lv_reset_ctrl dut (.*);
    // ------------------------------------------------------------
    // Clock, verdict and tasks
    // ------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // A seen bvalid ends the wait for the answer; failing that, the watchdog does
        forever
        begin
            @(posedge i_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic read_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        axi_read(a, rd, rsp);
        check(what, exp, rd);
    endtask
    task automatic wait_rst(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && o_system_reset !== v; n++) settle(1);
        check("system reset", v, o_system_reset);
    endtask
    function automatic logic exp_det(input logic [7:0] c, input logic stop);
        return c[0] && (!stop || c[2]);
    endfunction
    function automatic logic [1:0] exp_mode(input logic [7:0] c, input logic req, deep);
        if (!req) return 2'h0;
        return (deep && !(c[0] && c[2])) ? 2'h2 : 2'h1;
    endfunction
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {i_por_detect, i_below_low, i_reset} = 3'h7;
        {i_below_high, i_warning_detect, i_stop_request, i_stop_deep} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
        fail_count = 0;
        n_compared = 0;
        void'($urandom(54255));
        settle(12);
        check("reset during por", 1'b1, o_system_reset);
        i_reset <= 1'b0;
        s_axi_wstrb <= 4'hf;
        settle(20);
        check("held by por", 1'b1, o_system_reset);
        i_por_detect <= 1'b0;
        settle(20);
        check("held below low", 1'b1, o_system_reset);
        i_below_low <= 1'b0;
        wait_rst(1'b0, 20);
        read_chk("cause after por", 4'h4, 32'h82);
        read_chk("control reset", 4'h0, 32'h1c);
        axi_read(4'h8, rd, rsp);
        axi_write(4'h4, 32'h0, rsp);
        check("write bresp", 2'h0, rsp);
        read_chk("cause read only", 4'h4, 32'h82);
        axi_read(4'h2, rd, rsp);
        check("unmapped rresp", 2'h2, rsp);
        // Random control and stop requests, low-supply reset kept off
        for (int i = 0; i < 24; i++)
        begin
            // Every eighth pass forces both enables with a deep request
            ctl = (i % 8 == 0) ? 8'h05 : 8'($urandom) & 8'h15;
            axi_write(4'h0, {24'h0, ctl}, rsp);
            @(posedge i_clk);
            i_stop_request <= (i % 8 == 0) ? 1'b1 : 1'($urandom);
            i_stop_deep <= (i % 4 == 0) ? 1'b1 : 1'($urandom);
            settle(4);
            check("detector on", exp_det(ctl, i_stop_request), o_detector_on);
            check("stop mode", exp_mode(ctl, i_stop_request, i_stop_deep), o_stop_mode);
            check("threshold", ctl[4], o_threshold_high);
        end
        i_stop_request <= 1'b0;
        // Detector off: comparators ignored
        axi_write(4'h0, 32'h28, rsp);
        @(posedge i_clk);
        {i_below_low, i_below_high, i_warning_detect} <= 3'h7;
        settle(12);
        check("no reset when off", 1'b0, o_system_reset);
        check("no warning when off", 1'b0, o_warning_irq);
        read_chk("no flag when off", 4'h0, 32'h28);
        {i_below_low, i_below_high} <= 2'h0;
        // Warning flag, interrupt, acknowledge and event status
        axi_write(4'h0, 32'h21, rsp);
        axi_write(4'hc, 32'h1, rsp);
        settle(6);
        check("warning irq", 1'b1, o_warning_irq);
        check("masked irq", 1'b1, o_irq);
        read_chk("warning flag", 4'h0, 32'ha1);
        axi_write(4'hc, 32'h0, rsp);
        settle(2);
        check("irq masked off", 1'b0, o_irq);
        i_warning_detect <= 1'b0;
        axi_write(4'h0, 32'h61, rsp);
        read_chk("flag acked", 4'h0, 32'h21);
        check("warning irq off", 1'b0, o_warning_irq);
        read_chk("status warning", 4'h8, 32'h1);
        read_chk("status cleared", 4'h8, 32'h0);
        // Low-supply reset at each threshold
        axi_write(4'hc, 32'h2, rsp);
        for (int t = 0; t < 2; t++)
        begin
            axi_write(4'h0, {27'h0, t[0], 4'h9}, rsp);
            @(posedge i_clk);
            i_below_high <= 1'b1;
            settle(10);
            check("high level only", t[0], o_system_reset);
            i_below_low <= 1'b1;
            wait_rst(1'b1, 10);
            settle(20);
            check("held while low", 1'b1, o_system_reset);
            {i_below_low, i_below_high} <= 2'h0;
            wait_rst(1'b0, 20);
            read_chk("cause after low", 4'h4, 32'h2);
            check("event irq", 1'b1, o_irq);
            read_chk("status low reset", 4'h8, 32'h2);
        end
        // Power-on from run: both causes recorded, no event status
        i_por_detect <= 1'b1;
        wait_rst(1'b1, 10);
        read_chk("cause after run por", 4'h4, 32'h82);
        i_por_detect <= 1'b0;
        wait_rst(1'b0, 20);
        settle(3);
        check("irq after read", 1'b0, o_irq);
        end_sim();
    end
endmodule // tb_top
